// ---- verilog/event_counter_defs.vh ----
`ifndef EVENT_COUNTER_DEFS_VH
`define EVENT_COUNTER_DEFS_VH

// ==========================================================
// Register byte addresses
`define ADDR_TIMER_MODE 12'h000
`define ADDR_MAIN_COUNT 12'h004
`define ADDR_PRESCALER 12'h008
`define ADDR_UNIT_CONFIG 12'h00c
`define ADDR_EVENT_STATUS 12'h010

// ==========================================================
// Field positions
`define MODE_RUN_BIT 0
`define MODE_EDGE_BIT 1
`define CONFIG_PIN_BIT 0
`define STATUS_PEND_BIT 0
`define STATUS_MAIN_BIT 1
`define STATUS_PRE_BIT 2

// ==========================================================
// Reset values
`define RESET_COUNT 8'hff
`define RESET_MODE 2'h0

`endif

// ---- verilog/edge_sync.v ----
`timescale 1ns/1ps
// Two-flop synchroniser of a pin with edge detection on the synced value
module edge_sync (
    input wire clk,
    input wire reset_n,
    input wire pinIn,
    input wire risingSel,
    output wire syncLevel,
    output wire activeEdge
);
    reg meta;
    reg stable;
    reg prev;
    reg [1:0] warm;

    // ==========================================================
    // Synchroniser and history
    always @(posedge clk) begin
        if (!reset_n) begin
            meta <= 1'b0;
            stable <= 1'b0;
            prev <= 1'b0;
            warm <= 2'b00;
        end else begin
            meta <= pinIn;
            stable <= meta;
            prev <= stable;
            warm <= {warm[0], 1'b1};
        end
    end

    // Chosen edge seen on synced level; muted for two cycles after reset, though prev holds a real pin value only after three
    assign syncLevel = stable;
    assign activeEdge = warm[1] & (risingSel ? (stable & ~prev) : (~stable & prev));
endmodule // edge_sync

// ---- verilog/event_counter_timer.v ----
`timescale 1ns/1ps
`include "event_counter_defs.vh"

// Overview of operation
// - Counter decrements only on the selected edge of the chosen event pin.
// - Both stages count down and reload on underflow, continuing.
// - Prescaler underflow clocks main stage: one main underflow per (n+1)(m+1).
// - Writing one to the run bit starts counting.
// - Writing zero to the run bit stops counting.
// - Each main underflow raises the timer interrupt request.
// - The selected event pin also feeds the external interrupt one input.
// - Reads of count registers return live counts, not reload values.
// - Write while stopped loads reload register and counter together.
// - Write while running: reload at event 1, counter at 2, event 3 dropped, counting resumes at 4.
// - Edge select bit picks rising or falling event edges.
// - Pin select bit routes input a or input b to the counter.
module event_counter_timer #(
    parameter WIDTH = 8
) (
    input wire clk,
    input wire reset_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire eventInputA,
    input wire eventInputB,
    output wire timerIrq,
    output wire extIrqOne,
    output wire extIrqEdge
);
    // ==========================================================
    // State
    reg runControlBit;
    reg edgePolaritySelect;
    reg inputPinSelect;
    reg [WIDTH-1:0] mainCount;
    reg [WIDTH-1:0] prescalerCounter;
    reg [WIDTH-1:0] mainReload;
    reg [WIDTH-1:0] preReload;
    reg [WIDTH-1:0] mainPend;
    reg [WIDTH-1:0] prePend;
    reg mainPendValid;
    reg prePendValid;
    reg [1:0] loadPhase;
    reg timerPulse;
    reg [1:0] next_loadPhase;

    localparam PH_IDLE = 2'd0;
    localparam PH_TRANSFER = 2'd1;
    localparam PH_RESUME = 2'd2;

    wire syncA;
    wire syncB;
    wire edgeA;
    wire edgeB;
    wire countEvent;
    wire wrEn;
    wire wrMain;
    wire wrPre;
    wire anyPend;
    wire preUnder;

    // Address match helper
    function hit;
        input [11:0] a;
        input [11:0] b;
        begin
            hit = (a == b);
        end
    endfunction

    // Underflow test on a count value
    function isZero;
        input [WIDTH-1:0] v;
        begin
            isZero = (v == {WIDTH{1'b0}});
        end
    endfunction

    // One count-down step, reload on underflow
    function [WIDTH-1:0] stepDown;
        input [WIDTH-1:0] v;
        input [WIDTH-1:0] reload;
        begin
            if (v == {WIDTH{1'b0}}) begin
                stepDown = reload;
            end else begin
                stepDown = v - {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
    endfunction

    // ==========================================================
    // Pin synchronisers
    edge_sync u_syncA (
        .clk(clk),
        .reset_n(reset_n),
        .pinIn(eventInputA),
        .risingSel(edgePolaritySelect),
        .syncLevel(syncA),
        .activeEdge(edgeA)
    );
    edge_sync u_syncB (
        .clk(clk),
        .reset_n(reset_n),
        .pinIn(eventInputB),
        .risingSel(edgePolaritySelect),
        .syncLevel(syncB),
        .activeEdge(edgeB)
    );

    // Pin route and edge choice
    assign countEvent = inputPinSelect ? edgeB : edgeA;
    // External interrupt one shares the selected pin
    assign extIrqOne = inputPinSelect ? syncB : syncA;
    assign extIrqEdge = countEvent;

    // ==========================================================
    // APB slave, zero wait states
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign wrEn = psel & penable & pwrite;
    assign wrMain = wrEn & hit(paddr, `ADDR_MAIN_COUNT);
    assign wrPre = wrEn & hit(paddr, `ADDR_PRESCALER);
    assign anyPend = mainPendValid | prePendValid;
    assign preUnder = isZero(prescalerCounter);

    // Read mux, live counts
    always @* begin
        prdata = 32'h0;
        case (paddr)
            `ADDR_TIMER_MODE: begin
                prdata[`MODE_RUN_BIT] = runControlBit;
                prdata[`MODE_EDGE_BIT] = edgePolaritySelect;
            end
            `ADDR_MAIN_COUNT: prdata[WIDTH-1:0] = mainCount;
            `ADDR_PRESCALER: prdata[WIDTH-1:0] = prescalerCounter;
            `ADDR_UNIT_CONFIG: prdata[`CONFIG_PIN_BIT] = inputPinSelect;
            `ADDR_EVENT_STATUS: begin
                prdata[`STATUS_PEND_BIT] = (loadPhase != PH_IDLE) | anyPend;
                prdata[`STATUS_MAIN_BIT] = mainPendValid;
                prdata[`STATUS_PRE_BIT] = prePendValid;
            end
            default: prdata = 32'h0;
        endcase
    end

    // Control registers
    always @(posedge clk) begin
        if (!reset_n) begin
            runControlBit <= 1'b0;
            edgePolaritySelect <= 1'b0;
            inputPinSelect <= 1'b0;
        end else if (wrEn) begin
            if (hit(paddr, `ADDR_TIMER_MODE)) begin
                runControlBit <= pwdata[`MODE_RUN_BIT];
                edgePolaritySelect <= pwdata[`MODE_EDGE_BIT];
            end
            if (hit(paddr, `ADDR_UNIT_CONFIG)) begin
                inputPinSelect <= pwdata[`CONFIG_PIN_BIT];
            end
        end
    end

    // ==========================================================
    // Running-write sequence phase
    always @* begin
        next_loadPhase = loadPhase;
        if (runControlBit && countEvent) begin
            case (loadPhase)
                PH_IDLE: begin
                    if (anyPend) begin
                        next_loadPhase = PH_TRANSFER;
                    end
                end
                PH_TRANSFER: begin
                    next_loadPhase = PH_RESUME;
                end
                PH_RESUME: begin
                    next_loadPhase = PH_IDLE;
                end
                default: begin
                    next_loadPhase = PH_IDLE;
                end
            endcase
        end
        // Stopping abandons any write sequence
        if (!runControlBit) begin
            next_loadPhase = PH_IDLE;
        end
    end

    // ==========================================================
    // Event qualifiers for the counting path
    wire countStep;
    wire consumeEvent;
    wire transferEvent;
    wire mainUnder;

    // At most one qualifier is high in any cycle
    assign mainUnder = isZero(mainCount);
    assign consumeEvent = runControlBit & countEvent & (loadPhase == PH_IDLE) & anyPend;
    assign transferEvent = runControlBit & countEvent & (loadPhase == PH_TRANSFER);
    assign countStep = runControlBit & countEvent & (loadPhase == PH_IDLE) & ~anyPend;

    reg [WIDTH-1:0] next_mainCount;
    reg [WIDTH-1:0] next_prescalerCounter;
    reg [WIDTH-1:0] next_mainReload;
    reg [WIDTH-1:0] next_preReload;
    reg [WIDTH-1:0] next_mainPend;
    reg [WIDTH-1:0] next_prePend;
    reg next_mainPendValid;
    reg next_prePendValid;
    reg next_timerPulse;

    // ==========================================================
    // Next counts and reloads
    always @* begin
        next_mainCount = mainCount;
        next_prescalerCounter = prescalerCounter;
        next_mainReload = mainReload;
        next_preReload = preReload;
        next_timerPulse = 1'b0;
        if (!runControlBit) begin
            // Stopped: load both at once
            if (wrMain) begin
                next_mainReload = pwdata[WIDTH-1:0];
                next_mainCount = pwdata[WIDTH-1:0];
            end
            if (wrPre) begin
                next_preReload = pwdata[WIDTH-1:0];
                next_prescalerCounter = pwdata[WIDTH-1:0];
            end
        end else if (consumeEvent) begin
            // First event: reload registers take data
            if (mainPendValid) begin
                next_mainReload = mainPend;
            end
            if (prePendValid) begin
                next_preReload = prePend;
            end
        end else if (transferEvent) begin
            // Second event: counters take reloads
            next_mainCount = mainReload;
            next_prescalerCounter = preReload;
        end else if (countStep) begin
            // Prescaler steps on each event, main on its underflow
            next_prescalerCounter = stepDown(prescalerCounter, preReload);
            if (preUnder) begin
                next_mainCount = stepDown(mainCount, mainReload);
                next_timerPulse = mainUnder;
            end
        end
    end

    // Next pending writes; set wins over the consume clear
    always @* begin
        next_mainPend = mainPend;
        next_prePend = prePend;
        next_mainPendValid = mainPendValid;
        next_prePendValid = prePendValid;
        if (!runControlBit) begin
            // Stopping discards pending writes
            next_mainPendValid = 1'b0;
            next_prePendValid = 1'b0;
        end else begin
            if (consumeEvent) begin
                next_mainPendValid = 1'b0;
                next_prePendValid = 1'b0;
            end
            if (wrMain) begin
                next_mainPend = pwdata[WIDTH-1:0];
                next_mainPendValid = 1'b1;
            end
            if (wrPre) begin
                next_prePend = pwdata[WIDTH-1:0];
                next_prePendValid = 1'b1;
            end
        end
    end

    // ==========================================================
    // Counter and reload registers
    always @(posedge clk) begin
        if (!reset_n) begin
            mainCount <= `RESET_COUNT;
            prescalerCounter <= `RESET_COUNT;
            mainReload <= `RESET_COUNT;
            preReload <= `RESET_COUNT;
        end else begin
            mainCount <= next_mainCount;
            prescalerCounter <= next_prescalerCounter;
            mainReload <= next_mainReload;
            preReload <= next_preReload;
        end
    end

    // Pending write latch
    always @(posedge clk) begin
        if (!reset_n) begin
            mainPend <= `RESET_COUNT;
            prePend <= `RESET_COUNT;
            mainPendValid <= 1'b0;
            prePendValid <= 1'b0;
        end else begin
            mainPend <= next_mainPend;
            prePend <= next_prePend;
            mainPendValid <= next_mainPendValid;
            prePendValid <= next_prePendValid;
        end
    end

    // Write sequence phase and underflow pulse
    always @(posedge clk) begin
        if (!reset_n) begin
            loadPhase <= PH_IDLE;
            timerPulse <= 1'b0;
        end else begin
            loadPhase <= next_loadPhase;
            timerPulse <= next_timerPulse;
        end
    end

    assign timerIrq = timerPulse;
endmodule // event_counter_timer

// ---- verification/event_counter_timer_props.sv ----
`timescale 1ns/1ps
module event_counter_timer_props (
    input wire clk,
    input wire reset_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire timerIrq,
    input wire extIrqOne,
    input wire extIrqEdge
);
    // ==========
    // Bus and event checks
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence rdAny;
        psel && penable && !pwrite;
    endsequence
    sequence rdHigh;
        psel && penable && !pwrite && (paddr > 12'h010);
    endsequence
    ready_high_a: assert property (psel && penable |-> pready) else $error("no ready");
    no_error_a: assert property (psel && penable |-> !pslverr) else $error("slave error");
    unmapped_zero_a: assert property (rdHigh |-> prdata == 32'h00000000) else $error("hole data");
    upper_zero_a: assert property (rdAny |-> prdata[31:8] == 24'h000000) else $error("upper bits");
    irq_pulse_a: assert property (timerIrq |=> !timerIrq) else $error("irq too long");
    irq_cause_a: assert property (timerIrq |-> $past(extIrqEdge)) else $error("irq no event");
    edge_level_a: assert property (extIrqEdge |-> extIrqOne != $past(extIrqOne)) else $error("edge");
    edge_gap_a: assert property (extIrqEdge |=> !extIrqEdge) else $error("edge twice");
endmodule // event_counter_timer_props

bind event_counter_timer event_counter_timer_props props_i (.clk(clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timerIrq(timerIrq), .extIrqOne(extIrqOne),
    .extIrqEdge(extIrqEdge));

// ---- verification/event_source.sv ----
`timescale 1ns/1ps
module event_source (
    input wire clk,
    output reg pinA,
    output reg pinB
);
    // Both pins idle high
    initial begin
        pinA = 1'b1;
        pinB = 1'b1;
    end
    // Toggle the chosen pin k times, one edge every 4 clocks
    task toggle(input sel, input integer k);
        integer t;
        begin
            for (t = 0; t < k; t++) begin
                repeat (4) @(posedge clk);
                if (sel) pinB <= ~pinB;
                else pinA <= ~pinA;
            end
        end
    endtask
endmodule // event_source

// ---- verification/event_counter_timer_test.sv ----
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errCount++; \
    $display("unexpected %0t %h %h", $time, a, e); end end
module event_counter_timer_test;
    // ==========
    // Signals
    reg clk = 1'b0;
    reg reset_n = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h00000000;
    reg [31:0] rd;
    reg [31:0] r;
    reg lvl;
    reg e;
    wire [31:0] prdata;
    wire pready, pslverr, pinA, pinB, timerIrq, extIrqOne, extIrqEdge;
    integer errCount = 0, checks = 0, irqs = 0, i, j, ev, n, m, u;
    integer irqBase = 0, edges = 0, edgeBase = 0;
    // Rows: pin, edge, prescale n, main m, toggles
    reg [31:0] rows [0:3] = '{32'h00020107, 32'h11000309, 32'h01030008, 32'h1001020d};

    event_counter_timer event_counter_timer_i (.clk(clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .eventInputA(pinA), .eventInputB(pinB),
        .timerIrq(timerIrq), .extIrqOne(extIrqOne), .extIrqEdge(extIrqEdge));
    event_source event_source_i (.clk(clk), .pinA(pinA), .pinB(pinB));

    // Clock and interrupt count
    always #50 clk = ~clk;
    always @(posedge clk) if (timerIrq === 1'b1) irqs <= irqs + 1;
    always @(posedge clk) if (extIrqEdge === 1'b1) edges <= edges + 1;

    // ==========
    // Tasks
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk);
            penable <= 1'b1;
            @(posedge clk);
            while (pready !== 1'b1) @(posedge clk);
            rd = prdata;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge clk);
        end
    endtask
    task one_event;
        begin
            event_source_i.toggle(1'b0, 2);
            repeat (4) @(posedge clk);
        end
    endtask
    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", checks, errCount);
            if (errCount == 0 && checks > 0) $display("DONE - PASS");
            else $display("DONE - FAIL");
            $finish;
        end
    endtask

    // Watchdog
    initial begin
        repeat (20000) @(posedge clk);
        errCount++;
        tally_and_finish;
    end

    // ==========
    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        for (i = 0; i < 4; i++) begin
            r = rows[i];
            n = r[23:16];
            m = r[15:8];
            apb(1'b1, 12'h000, {30'h0, r[24], 1'b0});
            apb(1'b1, 12'h00c, {31'h0, r[28]});
            apb(1'b1, 12'h008, {24'h0, r[23:16]});
            apb(1'b1, 12'h004, {24'h0, r[15:8]});
            apb(1'b0, 12'h004, 32'h0);
            `CHK(rd, m)
            lvl = r[28] ? pinB : pinA;
            ev = 0;
            for (j = 0; j < r[7:0]; j++) begin
                lvl = ~lvl;
                if (lvl == r[24]) ev++;
            end
            irqBase = irqs;
            edgeBase = edges;
            apb(1'b1, 12'h000, {30'h0, r[24], 1'b1});
            event_source_i.toggle(r[28], r[7:0]);
            repeat (6) @(posedge clk);
            apb(1'b1, 12'h000, {30'h0, r[24], 1'b0});
            u = ev / (n + 1);
            apb(1'b0, 12'h008, 32'h0);
            `CHK(rd, n - ev % (n + 1))
            apb(1'b0, 12'h004, 32'h0);
            `CHK(rd, m - u % (m + 1))
            `CHK(irqs - irqBase, u / (m + 1))
            `CHK(edges - edgeBase, ev)
            `CHK(extIrqOne, lvl)
            $display("row %0d done", i);
        end
        // Write while running, then stop
        e = ~pinA;
        apb(1'b1, 12'h00c, 32'h0);
        apb(1'b1, 12'h008, 32'h0);
        apb(1'b1, 12'h004, 32'h5);
        apb(1'b1, 12'h000, {30'h0, e, 1'b1});
        apb(1'b1, 12'h004, 32'h2);
        apb(1'b0, 12'h010, 32'h0);
        `CHK(rd, 32'h3)
        one_event;
        one_event;
        apb(1'b0, 12'h004, 32'h0);
        `CHK(rd, 32'h2)
        one_event;
        apb(1'b0, 12'h004, 32'h0);
        `CHK(rd, 32'h2)
        one_event;
        apb(1'b0, 12'h004, 32'h0);
        `CHK(rd, 32'h1)
        apb(1'b1, 12'h000, {30'h0, e, 1'b0});
        one_event;
        apb(1'b0, 12'h004, 32'h0);
        `CHK(rd, 32'h1)
        apb(1'b1, 12'h020, 32'hffffffff);
        apb(1'b0, 12'h020, 32'h0);
        `CHK(rd, 32'h0)
        $display("running write done");
        // Reset after the stop, run bit already clear
        reset_n <= 1'b0;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        apb(1'b0, 12'h004, 32'h0);
        `CHK(rd, 32'h000000ff)
        apb(1'b0, 12'h008, 32'h0);
        `CHK(rd, 32'h000000ff)
        apb(1'b0, 12'h000, 32'h0);
        `CHK(rd, 32'h0)
        $display("reset done");
        tally_and_finish;
    end
endmodule // event_counter_timer_test
